// ---- hw/volt_limit_pkg.sv ----
// Functional notes
// - Input floor register is written as one 16-bit word; only code bits 13:6 are held.
// - Input floor code sits in bits 13:6, lsb worth 64 mV, binary weighted.
// - Bit 13 of the input floor adds 8192 mV when set.
// - A fixed 3.2 V offset is added to every input floor code, zero included.
// - Input below the floor enters input voltage regulation and cuts charge current.
// - Unwritten floor defaults to no-load bus voltage minus 1.28 V; code bits reset zero.
// - Input floor bits 5:0 are ignored and read as zero.
// - Minimum system code sits in bits 15:8, lsb 100 mV, msb 12800 mV, no offset.
// - Minimum system voltage is valid from 1.0 V to 19.2 V in 100 mV steps.
// - Nonzero minimum system writes outside 1.0 V to 19.2 V are discarded.
// - At power-on the minimum system voltage loads 3.6/6.6/9.2/12.3 V by cell count.
// - Writing zero to minimum system voltage restores the cell-count default.
`default_nettype none
package volt_limit_pkg;
  localparam logic [7:0] input_voltage_floor_cmd = 8'h3d;
  localparam logic [7:0] minimum_system_voltage_cmd = 8'h3e;
  localparam logic [6:0] dev_addr_default = 7'h09;
  // Field layout
  localparam int floor_code_lsb = 6;
  localparam int floor_code_msb = 13;
  localparam int floor_rsvd_msb = 15;
  localparam int floor_rsvd_lsb = 14;
  localparam int minsys_code_lsb = 8;
  localparam int minsys_code_msb = 15;
  localparam logic [7:0] floor_code_reset = 8'h00;
  // Scaling, millivolts
  localparam logic [15:0] floor_step_mv = 16'h0040;
  localparam logic [15:0] floor_offset_mv = 16'h0c80;
  localparam logic [15:0] floor_default_drop_mv = 16'h0500;
  localparam logic [15:0] minsys_step_mv = 16'h0064;
  // Minimum system code limits and per-cell defaults, 100 mV units
  localparam logic [7:0] minsys_code_min = 8'h0a;
  localparam logic [7:0] minsys_code_max = 8'hc0;
  localparam logic [7:0] minsys_default_1s = 8'h24;
  localparam logic [7:0] minsys_default_2s = 8'h42;
  localparam logic [7:0] minsys_default_3s = 8'h5c;
  localparam logic [7:0] minsys_default_4s = 8'h7b;
  localparam logic [1:0] strap_settle_cycles = 2'h3;

  typedef enum logic [1:0] {cell_1s, cell_2s, cell_3s, cell_4s} cell_count_t;

  typedef struct packed {
    logic input_voltage_regulation_mode;
    logic [15:0] input_floor_mv;
    logic [15:0] min_system_voltage_mv;
  } limit_status_t;
endpackage
`default_nettype wire

// ---- hw/input_and_min_system_voltage_regs.sv ----
`default_nettype none
module input_and_min_system_voltage_regs
  import volt_limit_pkg::*;
#(
  parameter logic [6:0] dev_addr = dev_addr_default
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [1:0] cell_count_config_pin,
  input wire logic [15:0] input_bus_voltage_mv,
  input wire logic [15:0] no_load_bus_voltage_mv,
  output logic [15:0] input_voltage_floor_word,
  output logic [15:0] minimum_system_voltage_word,
  output limit_status_t limit_status,
  output logic charge_current_reduce
);

  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_tx_ack} bus_state_t;

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic scl_s1_r, scl_s2_r, scl_d_r;
  logic sda_s1_r, sda_s2_r, sda_d_r;
  logic [1:0] cell_s1_r, cell_s2_r;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    cell_s1_r <= cell_count_config_pin;
    cell_s2_r <= cell_s1_r;
  end

  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  assign start_cond = scl_s2_r && scl_d_r && !sda_s2_r && sda_d_r;
  assign stop_cond = scl_s2_r && scl_d_r && sda_s2_r && !sda_d_r;

  // ****************************************
  // SMBus word slave
  // ****************************************
  bus_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_idx_r;
  logic read_r, sda_drive_r;
  logic [7:0] cmd_r, wr_lo_r, rd_hi_r;
  logic wr_commit;
  logic [15:0] wr_word;
  logic [15:0] rd_word;

  // Unmapped commands are acknowledged and read back zero
  always_comb begin
    unique case (cmd_r)
      input_voltage_floor_cmd: rd_word = input_voltage_floor_word;
      minimum_system_voltage_cmd: rd_word = minimum_system_voltage_word;
      default: rd_word = 16'h0000;
    endcase
  end

  // Commit when the high byte is acked; low byte arrived first
  logic wr_done_r;

  // Only the first high byte commits; trailing bytes would pair with a stale low byte
  always_ff @(posedge sys_clk) begin
    if (!nrst || start_cond) begin
      wr_done_r <= 1'b0;
    end else if (wr_commit) begin
      wr_done_r <= 1'b1;
    end
  end

  assign wr_commit = (state_r == st_rx) && scl_fall && (bit_cnt_r == 4'h8) && (byte_idx_r == 2'h3)
                     && !read_r && !wr_done_r;
  assign wr_word = {shift_r, wr_lo_r};

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= st_idle;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      read_r <= 1'b0;
      sda_drive_r <= 1'b0;
      cmd_r <= 8'h00;
      wr_lo_r <= 8'h00;
      rd_hi_r <= 8'h00;
    end else if (start_cond) begin
      // Repeated start keeps the command byte for the read phase
      state_r <= st_rx;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 2'h0;
      sda_drive_r <= 1'b0;
    end else if (stop_cond) begin
      state_r <= st_idle;
      sda_drive_r <= 1'b0;
    end else begin
      unique case (state_r)
        st_idle: begin
          sda_drive_r <= 1'b0;
        end
        st_rx: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (byte_idx_r == 2'h0 && shift_r[7:1] != dev_addr) begin
              state_r <= st_idle;
            end else begin
              state_r <= st_ack;
              sda_drive_r <= 1'b1;
              byte_idx_r <= (byte_idx_r == 2'h3) ? 2'h3 : byte_idx_r + 2'h1;
              unique case (byte_idx_r)
                2'h0: read_r <= shift_r[0];
                2'h1: cmd_r <= shift_r;
                2'h2: wr_lo_r <= shift_r;
                2'h3: ;
              endcase
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            if (read_r) begin
              // Low byte goes out first, high byte latched with it
              state_r <= st_tx;
              shift_r <= rd_word[7:0];
              rd_hi_r <= rd_word[15:8];
              sda_drive_r <= !rd_word[7];
            end else begin
              state_r <= st_rx;
              sda_drive_r <= 1'b0;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              bit_cnt_r <= 4'h0;
              state_r <= st_tx_ack;
              sda_drive_r <= 1'b0;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              shift_r <= {shift_r[6:0], 1'b0};
              sda_drive_r <= !shift_r[6];
            end
          end
        end
        st_tx_ack: begin
          if (scl_rise) begin
            read_r <= !sda_s2_r;
          end else if (scl_fall) begin
            if (read_r) begin
              state_r <= st_tx;
              shift_r <= rd_hi_r;
              rd_hi_r <= 8'h00;
              sda_drive_r <= !rd_hi_r[7];
            end else begin
              state_r <= st_idle;
            end
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_n = !sda_drive_r;

  // ****************************************
  // Input voltage floor register
  // ****************************************
  logic [7:0] floor_code_r;
  logic floor_written_r;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      floor_code_r <= floor_code_reset;
      floor_written_r <= 1'b0;
    end else if (wr_commit && cmd_r == input_voltage_floor_cmd
                 && wr_word[floor_rsvd_msb:floor_rsvd_lsb] == 2'b00) begin
      floor_code_r <= wr_word[floor_code_msb:floor_code_lsb];
      floor_written_r <= 1'b1;
    end
  end

  assign input_voltage_floor_word = {2'b00, floor_code_r, 6'b000000};

  // ****************************************
  // Minimum system voltage register
  // ****************************************
  logic [7:0] minsys_code_r;
  logic [7:0] cell_default;
  logic [1:0] strap_cnt_r;
  logic [7:0] minsys_wr;

  always_comb begin
    unique case (cell_count_t'(cell_s2_r))
      cell_1s: cell_default = minsys_default_1s;
      cell_2s: cell_default = minsys_default_2s;
      cell_3s: cell_default = minsys_default_3s;
      cell_4s: cell_default = minsys_default_4s;
    endcase
  end

  assign minsys_wr = wr_word[minsys_code_msb:minsys_code_lsb];

  // Strap is caught only after the synchroniser has filled
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strap_cnt_r <= 2'h0;
      minsys_code_r <= 8'h00;
    end else if (strap_cnt_r != strap_settle_cycles) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      minsys_code_r <= cell_default;
    end else if (wr_commit && cmd_r == minimum_system_voltage_cmd) begin
      if (minsys_wr == 8'h00) begin
        minsys_code_r <= cell_default;
      end else if (minsys_wr >= minsys_code_min && minsys_wr <= minsys_code_max) begin
        minsys_code_r <= minsys_wr;
      end
    end
  end

  assign minimum_system_voltage_word = {minsys_code_r, 8'h00};

  // ****************************************
  // Thresholds and regulation
  // ****************************************
  logic [15:0] floor_mv_nxt;
  logic [15:0] floor_mv_r, minsys_mv_r;
  logic in_reg_r;

  // Code weight 64 mV per lsb plus fixed offset; unwritten tracks the bus
  assign floor_mv_nxt = floor_written_r ? 16'(floor_code_r * floor_step_mv) + floor_offset_mv
                                        : no_load_bus_voltage_mv - floor_default_drop_mv;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      floor_mv_r <= 16'h0000;
      minsys_mv_r <= 16'h0000;
      in_reg_r <= 1'b0;
    end else begin
      floor_mv_r <= floor_mv_nxt;
      minsys_mv_r <= 16'(minsys_code_r * minsys_step_mv);
      in_reg_r <= input_bus_voltage_mv < floor_mv_r;
    end
  end

  assign limit_status = '{input_voltage_regulation_mode: in_reg_r, input_floor_mv: floor_mv_r,
                          min_system_voltage_mv: minsys_mv_r};
  assign charge_current_reduce = in_reg_r;

endmodule
`default_nettype wire

// ---- testbench/vlr_properties.sv ----
`default_nettype none
module vlr_properties
  import volt_limit_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_oe_n,
  input wire logic [1:0] cell_count_config_pin,
  input wire logic [15:0] input_bus_voltage_mv,
  input wire logic [15:0] input_voltage_floor_word,
  input wire logic [15:0] minimum_system_voltage_word,
  input wire limit_status_t limit_status,
  input wire logic charge_current_reduce
);
  timeunit 1ns / 1ns;
  // ****
  // Word, scaling and regulation relations
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] fc;
  logic [7:0] mc;
  logic [7:0] dflt;
  logic reg_on;
  logic below;
  assign fc = input_voltage_floor_word[13:6];
  assign mc = minimum_system_voltage_word[15:8];
  assign reg_on = limit_status.input_voltage_regulation_mode;
  assign below = input_bus_voltage_mv < limit_status.input_floor_mv;
  assign dflt = cell_count_config_pin[1] ? (cell_count_config_pin[0] ? minsys_default_4s : minsys_default_3s)
    : (cell_count_config_pin[0] ? minsys_default_2s : minsys_default_1s);
  property p_floor_fmt; (input_voltage_floor_word & 16'hc03f) == 16'h0000; endproperty
  a_floor_fmt: assert property (p_floor_fmt) else $error("floor reserved bits set");
  property p_minsys_low; minimum_system_voltage_word[7:0] == 8'h00; endproperty
  a_minsys_low: assert property (p_minsys_low) else $error("minsys low byte set");
  property p_floor_mv; $changed(fc) |=> limit_status.input_floor_mv == {8'h00, fc} * floor_step_mv + floor_offset_mv;
  endproperty
  a_floor_mv: assert property (p_floor_mv) else $error("floor mv wrong");
  property p_minsys_mv; $changed(mc) |=> limit_status.min_system_voltage_mv == {8'h00, mc} * minsys_step_mv; endproperty
  a_minsys_mv: assert property (p_minsys_mv) else $error("minsys mv wrong");
  property p_minsys_range; $changed(mc) |-> mc >= minsys_code_min && mc <= minsys_code_max; endproperty
  a_minsys_range: assert property (p_minsys_range) else $error("minsys out of range");
  property p_minsys_dflt; $rose(nrst) |-> ##3 mc == dflt; endproperty
  a_minsys_dflt: assert property (p_minsys_dflt) else $error("minsys default wrong");
  property p_regulate; charge_current_reduce == reg_on && reg_on == $past(below); endproperty
  a_regulate: assert property (p_regulate) else $error("regulation flag wrong");
  // Data may only move while the clock line is low
  property p_sda_chg; $changed(sda_oe_n) |-> !scl_i && !$past(scl_i, 2); endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("data moved with clock high");
  c_floor_write: cover property ($changed(fc));
  c_regulating: cover property ($rose(charge_current_reduce));
  c_minsys_dflt: cover property ($changed(mc) && mc == dflt);
endmodule
`default_nettype wire

// ---- testbench/smbus_host_model.sv ----
`default_nettype none
module smbus_host_model
  import volt_limit_pkg::*;
#(
  parameter logic [6:0] addr = dev_addr_default
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns / 1ns;
  // ****
  // Host bus cycles, ten clocks per clock phase
  // ****
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_pull <= !b;
    tick(5);
    scl <= 1'b1;
    tick(10);
    r = sda;
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
  endtask
  // Start leaves the clock low, stop leaves the bus idle high
  task automatic edge_cond(input logic start);
    tick(1);
    sda_pull <= !start;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sda_pull <= start;
    tick(5);
    scl <= !start;
    tick(5);
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, output logic acked);
    logic [8:0] r [4];
    edge_cond(1'b1);
    xfer({addr, 2'b01}, r[0]);
    xfer({cmd, 1'b1}, r[1]);
    xfer({data[7:0], 1'b1}, r[2]);
    xfer({data[15:8], 1'b1}, r[3]);
    edge_cond(1'b0);
    acked = !(r[0][0] | r[1][0] | r[2][0] | r[3][0]);
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] data);
    logic [8:0] r [5];
    edge_cond(1'b1);
    xfer({addr, 2'b01}, r[0]);
    xfer({cmd, 1'b1}, r[1]);
    edge_cond(1'b1);
    xfer({addr, 2'b11}, r[2]);
    xfer(9'h1fe, r[3]);
    xfer(9'h1ff, r[4]);
    edge_cond(1'b0);
    data = {r[4][8:1], r[3][8:1]};
  endtask
endmodule
`default_nettype wire

// ---- testbench/input_and_min_system_voltage_regs_test.sv ----
`default_nettype none
module input_and_min_system_voltage_regs_test
  import volt_limit_pkg::*;
;
  timeunit 1ns / 1ns;
  // ****
  // Bench, reference model and scenarios
  // ****
  logic sys_clk;
  logic nrst;
  logic scl;
  logic sda_pull;
  wire logic sda;
  logic sda_oe_n;
  logic sda_o;
  logic [1:0] cell_count_config_pin;
  logic [15:0] input_bus_voltage_mv;
  logic [15:0] no_load_bus_voltage_mv;
  logic [15:0] input_voltage_floor_word;
  logic [15:0] minimum_system_voltage_word;
  limit_status_t limit_status;
  logic charge_current_reduce;
  int miscompares = 0;
  int cmp_count = 0;
  int floor_code;
  int ms_code;
  bit floor_set;
  logic [15:0] rd;
  int dflt_tab [4] = '{36, 66, 92, 123};
  logic [15:0] fl_tab [5] = '{16'h2000, 16'h0000, 16'h4fc0, 16'h8000, 16'h3fff};
  logic [15:0] ms_tab [6] = '{16'h0a5a, 16'hc0ff, 16'h0900, 16'hc100, 16'h0000, 16'hff00};
  // Open drain with pull-up: released means high
  assign sda = !sda_pull && (sda_oe_n || sda_o);
  always #5 sys_clk = ~sys_clk;
  input_and_min_system_voltage_regs u_input_and_min_system_voltage_regs (.sys_clk, .nrst, .scl_i(scl), .sda_i(sda),
    .sda_o, .sda_oe_n, .cell_count_config_pin, .input_bus_voltage_mv, .no_load_bus_voltage_mv,
    .input_voltage_floor_word, .minimum_system_voltage_word, .limit_status, .charge_current_reduce);
  smbus_host_model u_smbus_host_model (.sys_clk, .sda, .scl, .sda_pull);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_all();
    logic [15:0] fmv;
    fmv = 16'(floor_set ? floor_code * 64 + 3200 : no_load_bus_voltage_mv - 1280);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      input_bus_voltage_mv <= fmv - 16'(k == 0);
      repeat (4) @(posedge sys_clk);
      #1;
      check("regulation", 16'(charge_current_reduce), 16'(k == 0));
    end
    check("floor word", input_voltage_floor_word, 16'(floor_code << 6));
    check("floor mv", limit_status.input_floor_mv, fmv);
    check("minsys word", minimum_system_voltage_word, 16'(ms_code << 8));
    check("minsys mv", limit_status.min_system_voltage_mv, 16'(ms_code * 100));
  endtask
  task automatic do_reset(input logic [1:0] c);
    @(posedge sys_clk);
    cell_count_config_pin <= c;
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    floor_set = 1'b0;
    floor_code = 0;
    ms_code = dflt_tab[c];
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    logic ok;
    logic [15:0] exp_q [$];
    u_smbus_host_model.write_word(cmd, d, ok);
    check("ack", 16'(ok), 16'h0001);
    if (cmd == 8'h3d && d[15:14] == 2'h0) begin
      floor_set = 1'b1;
      floor_code = int'(d[13:6]);
    end
    if (cmd == 8'h3e && d[15:8] == 8'h00) ms_code = dflt_tab[cell_count_config_pin];
    else if (cmd == 8'h3e && d[15:8] >= 8'h0a && d[15:8] <= 8'hc0) ms_code = int'(d[15:8]);
    check_all();
    exp_q.push_back(cmd == 8'h3d ? 16'(floor_code << 6) : cmd == 8'h3e ? 16'(ms_code << 8) : 16'h0000);
    u_smbus_host_model.read_word(cmd, rd);
    check("read back", rd, exp_q.pop_front());
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    cell_count_config_pin = 2'h0;
    input_bus_voltage_mv = 16'h0000;
    no_load_bus_voltage_mv = 16'h3a98;
    void'($urandom(34));
    for (int c = 0; c < 4; c++) begin
      do_reset(2'(c));
      check_all();
    end
    @(posedge sys_clk);
    no_load_bus_voltage_mv <= 16'($urandom_range(20000, 6000));
    // Model must read the new bus level, not the one before the update
    @(posedge sys_clk);
    check_all();
    foreach (fl_tab[i]) wr(8'h3d, fl_tab[i]);
    foreach (ms_tab[i]) wr(8'h3e, ms_tab[i]);
    wr(8'h3f, 16'h1234);
    repeat (4) begin
      // Full-width words also land on refused codes
      wr(8'h3d, 16'($urandom));
      wr(8'h3e, 16'($urandom));
    end
    finish_test();
  end
endmodule
bind input_and_min_system_voltage_regs vlr_properties u_vlr_properties (.sys_clk, .nrst, .scl_i, .sda_oe_n,
  .cell_count_config_pin, .input_bus_voltage_mv, .input_voltage_floor_word, .minimum_system_voltage_word,
  .limit_status, .charge_current_reduce);
`default_nettype wire
